/* pkg/fod_pkg.sv */
// ==========================================================================
// Constants, types and helpers shared by the operate dispatch block
package fod_pkg;

	// ==========================================================================
	// Register map, one aligned 32-bit word each
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0000_0008;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000C;
	localparam logic [31:0] ADDR_FREG_INDEX = 32'h0000_0010;
	localparam logic [31:0] ADDR_FREG_DATA = 32'h0000_0014;

	// Reset values
	localparam logic ALIGN_EN_RST = 1'h1;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

	// Trap type codes recorded with an outcome
	localparam logic [2:0] FTT_NONE = 3'h0;
	localparam logic [2:0] FTT_UNFINISHED = 3'h2;
	localparam logic [2:0] FTT_INVALID_REG = 3'h6;

	// Move operation masks
	localparam logic [31:0] SIGN_MASK = 32'h8000_0000;
	localparam logic [31:0] MAG_MASK = 32'h7FFF_FFFF;

	// Geometry
	localparam int WORD_W = 32;
	localparam int MAX_WORDS = 4;
	localparam int OPND_W = WORD_W * MAX_WORDS;
	localparam int REG_IDX_W = 5;
	localparam int REG_COUNT = 32;

	// ==========================================================================
	// Enumerations
	typedef enum logic [4:0] {
		INT_TO_SINGLE_OP, INT_TO_DOUBLE_OP, INT_TO_QUAD_OP,
		SINGLE_TO_INT_OP, DOUBLE_TO_INT_OP, QUAD_TO_INT_OP,
		SINGLE_TO_DOUBLE_OP, SINGLE_TO_QUAD_OP, DOUBLE_TO_SINGLE_OP,
		DOUBLE_TO_QUAD_OP, QUAD_TO_SINGLE_OP, QUAD_TO_DOUBLE_OP,
		SINGLE_COPY_OP, SINGLE_NEGATE_OP, SINGLE_MAGNITUDE_OP,
		SINGLE_ROOT_OP, DOUBLE_ROOT_OP, QUAD_ROOT_OP
	} fod_op_t;

	typedef enum logic [1:0] {PREC_S, PREC_D, PREC_Q} fod_prec_t;

	typedef enum logic [2:0] {ST_IDLE, ST_RD_ADDR, ST_RD_DATA, ST_CALL, ST_WR} fod_state_t;

	// ==========================================================================
	// Carriers
	typedef struct packed {
		fod_op_t op;
		logic [REG_IDX_W-1:0] rd;
		logic [REG_IDX_W-1:0] rs2;
	} fod_issue_t;

	typedef struct packed {
		logic valid;
		fod_op_t op;
		logic [OPND_W-1:0] operand;
	} fod_req_t;

	typedef struct packed {
		logic done;
		logic [OPND_W-1:0] result;
		logic [4:0] texc;
		logic [1:0] fcc;
		logic complete;
	} fod_rsp_t;

	typedef struct packed {
		logic done;
		logic trap;
		logic fp_exc;
		logic [2:0] ftt;
		logic [4:0] texc;
		logic [1:0] fcc;
	} fod_outcome_t;

	typedef struct packed {
		logic unfinished;
		logic misaligned;
		logic done;
	} fod_irq_t;

	typedef struct packed {
		logic [18:0] rsvd;
		logic busy;
		logic trap;
		logic fp_exc;
		logic [2:0] ftt;
		logic [4:0] texc;
		logic [1:0] fcc;
	} fod_status_t;

	typedef struct packed {
		fod_state_t state;
		logic [2:0] cnt;
		logic [REG_IDX_W-1:0] rd;
		logic [REG_IDX_W-1:0] rs2;
		logic [OPND_W-1:0] result;
		fod_req_t req;
		fod_outcome_t outc;
		logic ready;
		logic align_en;
		fod_irq_t int_stat;
		fod_irq_t int_mask;
		logic irq;
		logic [REG_IDX_W-1:0] freg_idx;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic apb_pend;
	} fod_regs_t;

	// ==========================================================================
	// Precision helpers
	function automatic fod_prec_t fod_src_prec(input fod_op_t op);
		unique case (op)
			DOUBLE_TO_INT_OP, DOUBLE_TO_SINGLE_OP, DOUBLE_TO_QUAD_OP, DOUBLE_ROOT_OP: return PREC_D;
			QUAD_TO_INT_OP, QUAD_TO_SINGLE_OP, QUAD_TO_DOUBLE_OP, QUAD_ROOT_OP: return PREC_Q;
			default: return PREC_S;
		endcase
	endfunction : fod_src_prec

	function automatic fod_prec_t fod_dst_prec(input fod_op_t op);
		unique case (op)
			INT_TO_DOUBLE_OP, SINGLE_TO_DOUBLE_OP, QUAD_TO_DOUBLE_OP, DOUBLE_ROOT_OP: return PREC_D;
			INT_TO_QUAD_OP, SINGLE_TO_QUAD_OP, DOUBLE_TO_QUAD_OP, QUAD_ROOT_OP: return PREC_Q;
			default: return PREC_S;
		endcase
	endfunction : fod_dst_prec

	function automatic logic [2:0] fod_words(input fod_prec_t p);
		unique case (p)
			PREC_D: return 3'h2;
			PREC_Q: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction : fod_words

	// First register of the group; low bits are dropped even when unchecked
	function automatic logic [REG_IDX_W-1:0] fod_base(input logic [REG_IDX_W-1:0] f, input fod_prec_t p);
		unique case (p)
			PREC_D: return {f[4:1], 1'h0};
			PREC_Q: return {f[4:2], 2'h0};
			default: return f;
		endcase
	endfunction : fod_base

	function automatic logic fod_misaligned(input logic [REG_IDX_W-1:0] f, input fod_prec_t p);
		unique case (p)
			PREC_D: return f[0];
			PREC_Q: return f[1:0] != 2'h0;
			default: return 1'h0;
		endcase
	endfunction : fod_misaligned

	// Moves the low group of a result up so the first register's word is on top
	function automatic logic [OPND_W-1:0] fod_align_top(input logic [OPND_W-1:0] v, input fod_prec_t p);
		return v << (WORD_W * (MAX_WORDS - int'(fod_words(p))));
	endfunction : fod_align_top

endpackage : fod_pkg

/* logic/fod_freg_mem.sv */
`timescale 1ns/100ps
// ==========================================================================
// Floating-point register file, one port, registered read data
module fod_freg_mem (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [fod_pkg::REG_IDX_W-1:0] addr_i,
	input wire logic [fod_pkg::WORD_W-1:0] wdata_i,
	output logic [fod_pkg::WORD_W-1:0] rdata_o
);

	logic [fod_pkg::WORD_W-1:0] mem_reg [fod_pkg::REG_COUNT];

	// Read returns the old word when written in the same cycle
	always_ff @(posedge clk_sys_i)
	begin
		if (we_i)
		begin
			mem_reg[addr_i] <= wdata_i;
		end
		rdata_o <= mem_reg[addr_i];
	end

endmodule : fod_freg_mem

/* logic/fod_dispatch.sv */
`timescale 1ns/100ps
// ==========================================================================
// Summary of operation
// - Quad destination uses rd bits 4:2 plus 00..11; nonzero low pair faults.
// - Quad second source uses rs2 bits 4:2 plus 00..11; nonzero low pair faults.
// - Misaligned fault raises trap and exception, records invalid-register type; check optional.
// - Returned result width follows destination precision: single, double or quad.
// - Routines return a five-bit exception vector beside the result.
// - Compare routines return a two-bit condition code in status-register encoding.
// - Every routine returns one completion bit.
// - Integer-to-float reads one register, result precision set by opcode.
// - Float-to-integer reads one, two or four registers, returns integer.
// - Format conversions read source-sized group, write destination-sized group.
// - Copy, negate bit 31, magnitude mask; exceptions zero, completion one.
// - Square root reads one, two or four registers by precision.
module fod_dispatch (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o,
	input wire logic issue_valid_i,
	input wire fod_pkg::fod_issue_t issue_i,
	output logic issue_ready_o,
	output fod_pkg::fod_outcome_t outcome_o,
	output fod_pkg::fod_req_t rtn_req_o,
	input wire fod_pkg::fod_rsp_t rtn_rsp_i
);

	// ==========================================================================
	// Reset release
	logic [1:0] rst_sync_reg;
	logic rst_n;

	// Release is synchronised so all state leaves reset on the same edge
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_sync_reg <= 2'h0;
		end
		else
		begin
			rst_sync_reg <= {rst_sync_reg[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ==========================================================================
	// Register file
	logic mem_we;
	logic [fod_pkg::REG_IDX_W-1:0] mem_addr;
	logic [fod_pkg::WORD_W-1:0] mem_wdata;
	logic [fod_pkg::WORD_W-1:0] mem_rdata;

	fod_freg_mem u_freg (
		.clk_sys_i(clk_sys_i),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdata),
		.rdata_o(mem_rdata)
	);

	// ==========================================================================
	// State
	fod_pkg::fod_regs_t s_reg;
	fod_pkg::fod_regs_t s_next;
	fod_pkg::fod_prec_t src_p;
	fod_pkg::fod_prec_t dst_p;
	fod_pkg::fod_prec_t iss_src_p;
	fod_pkg::fod_prec_t iss_dst_p;
	fod_pkg::fod_irq_t ev;
	fod_pkg::fod_irq_t clr;
	fod_pkg::fod_status_t status;
	logic apb_acc;
	logic [31:0] mv_word;

	assign src_p = fod_pkg::fod_src_prec(s_reg.req.op);
	assign dst_p = fod_pkg::fod_dst_prec(s_reg.req.op);
	assign iss_src_p = fod_pkg::fod_src_prec(issue_i.op);
	assign iss_dst_p = fod_pkg::fod_dst_prec(issue_i.op);
	assign apb_acc = psel_i && penable_i && !s_reg.pready;

	// Single-precision moves work on the last word read, no routine needed
	always_comb
	begin
		unique case (s_reg.req.op)
			fod_pkg::SINGLE_NEGATE_OP: mv_word = mem_rdata ^ fod_pkg::SIGN_MASK;
			fod_pkg::SINGLE_MAGNITUDE_OP: mv_word = mem_rdata & fod_pkg::MAG_MASK;
			default: mv_word = mem_rdata;
		endcase
	end

	// Status word as software sees it
	always_comb
	begin
		status = '0;
		status.busy = s_reg.state != fod_pkg::ST_IDLE;
		status.trap = s_reg.outc.trap;
		status.fp_exc = s_reg.outc.fp_exc;
		status.ftt = s_reg.outc.ftt;
		status.texc = s_reg.outc.texc;
		status.fcc = s_reg.outc.fcc;
	end

	// ==========================================================================
	// Next state: sequencer, bus slave, interrupt
	always_comb
	begin
		s_next = s_reg;
		ev = '0;
		clr = '0;
		mem_we = 1'h0;
		mem_addr = s_reg.freg_idx;
		mem_wdata = pwdata_i;
		s_next.outc.done = 1'h0;
		unique case (s_reg.state)
			fod_pkg::ST_IDLE:
			begin
				if (issue_valid_i)
				begin
					s_next.req.op = issue_i.op;
					s_next.req.operand = '0;
					s_next.rd = issue_i.rd;
					s_next.rs2 = issue_i.rs2;
					s_next.cnt = 3'h0;
					s_next.outc.trap = 1'h0;
					s_next.outc.fp_exc = 1'h0;
					s_next.outc.ftt = fod_pkg::FTT_NONE;
					// Alignment check can be turned off; low bits are then ignored
					if (s_reg.align_en && (fod_pkg::fod_misaligned(issue_i.rd, iss_dst_p)
						|| fod_pkg::fod_misaligned(issue_i.rs2, iss_src_p)))
					begin
						s_next.outc.trap = 1'h1;
						s_next.outc.fp_exc = 1'h1;
						s_next.outc.ftt = fod_pkg::FTT_INVALID_REG;
						s_next.outc.done = 1'h1;
						ev.misaligned = 1'h1;
						ev.done = 1'h1;
					end
					else
					begin
						s_next.state = fod_pkg::ST_RD_ADDR;
					end
				end
			end
			fod_pkg::ST_RD_ADDR:
			begin
				// Group of one, two or four source registers
				mem_addr = fod_pkg::fod_base(s_reg.rs2, src_p) | {3'h0, s_reg.cnt[1:0]};
				s_next.state = fod_pkg::ST_RD_DATA;
			end
			fod_pkg::ST_RD_DATA:
			begin
				s_next.req.operand = {s_reg.req.operand[fod_pkg::OPND_W-fod_pkg::WORD_W-1:0], mem_rdata};
				s_next.cnt = s_reg.cnt + 3'h1;
				if (s_reg.cnt + 3'h1 == fod_pkg::fod_words(src_p))
				begin
					s_next.cnt = 3'h0;
					if (s_reg.req.op inside {fod_pkg::SINGLE_COPY_OP, fod_pkg::SINGLE_NEGATE_OP,
						fod_pkg::SINGLE_MAGNITUDE_OP})
					begin
						s_next.result = fod_pkg::fod_align_top({96'h0, mv_word}, fod_pkg::PREC_S);
						s_next.outc.texc = 5'h0;
						s_next.state = fod_pkg::ST_WR;
					end
					else
					begin
						s_next.req.valid = 1'h1;
						s_next.state = fod_pkg::ST_CALL;
					end
				end
				else
				begin
					s_next.state = fod_pkg::ST_RD_ADDR;
				end
			end
			fod_pkg::ST_CALL:
			begin
				if (rtn_rsp_i.done)
				begin
					s_next.req.valid = 1'h0;
					s_next.outc.texc = rtn_rsp_i.texc;
					s_next.outc.fcc = rtn_rsp_i.fcc;
					if (!rtn_rsp_i.complete)
					begin
						// Unfinished work is left for software, registers untouched
						s_next.outc.trap = 1'h1;
						s_next.outc.fp_exc = 1'h1;
						s_next.outc.ftt = fod_pkg::FTT_UNFINISHED;
						s_next.outc.done = 1'h1;
						ev.unfinished = 1'h1;
						ev.done = 1'h1;
						s_next.state = fod_pkg::ST_IDLE;
					end
					else
					begin
						s_next.result = fod_pkg::fod_align_top(rtn_rsp_i.result, dst_p);
						s_next.state = fod_pkg::ST_WR;
					end
				end
			end
			fod_pkg::ST_WR:
			begin
				// Destination group sized by destination precision
				mem_we = 1'h1;
				mem_addr = fod_pkg::fod_base(s_reg.rd, dst_p) | {3'h0, s_reg.cnt[1:0]};
				mem_wdata = s_reg.result[fod_pkg::OPND_W-1 -: fod_pkg::WORD_W];
				s_next.result = {s_reg.result[fod_pkg::OPND_W-fod_pkg::WORD_W-1:0], 32'h0};
				s_next.cnt = s_reg.cnt + 3'h1;
				if (s_reg.cnt + 3'h1 == fod_pkg::fod_words(dst_p))
				begin
					s_next.cnt = 3'h0;
					s_next.outc.done = 1'h1;
					ev.done = 1'h1;
					s_next.state = fod_pkg::ST_IDLE;
				end
			end
		endcase

		// APB slave: answer one cycle after the access phase opens, two for register-file data reads
		s_next.pready = 1'h0;
		s_next.pslverr = 1'h0;
		if (apb_acc)
		begin
			s_next.pready = 1'h1;
			s_next.prdata = 32'h0;
			if (paddr_i == fod_pkg::ADDR_CTRL)
			begin
				s_next.prdata = 32'(s_reg.align_en);
				if (pwrite_i)
				begin
					s_next.align_en = pwdata_i[0];
				end
			end
			else if (paddr_i == fod_pkg::ADDR_STATUS)
			begin
				s_next.prdata = 32'(status);
			end
			else if (paddr_i == fod_pkg::ADDR_IRQ_STATUS)
			begin
				s_next.prdata = 32'(s_reg.int_stat);
				if (pwrite_i)
				begin
					clr = fod_pkg::fod_irq_t'(pwdata_i[2:0]);
				end
			end
			else if (paddr_i == fod_pkg::ADDR_IRQ_MASK)
			begin
				s_next.prdata = 32'(s_reg.int_mask);
				if (pwrite_i)
				begin
					s_next.int_mask = fod_pkg::fod_irq_t'(pwdata_i[2:0]);
				end
			end
			else if (paddr_i == fod_pkg::ADDR_FREG_INDEX)
			begin
				s_next.prdata = 32'(s_reg.freg_idx);
				if (pwrite_i)
				begin
					s_next.freg_idx = pwdata_i[4:0];
				end
			end
			else if (paddr_i == fod_pkg::ADDR_FREG_DATA)
			begin
				// The sequencer owns the port while busy, so software waits
				s_next.pready = 1'h0;
				if (s_reg.apb_pend)
				begin
					s_next.prdata = mem_rdata;
					s_next.pready = 1'h1;
					s_next.apb_pend = 1'h0;
				end
				else if (s_reg.state == fod_pkg::ST_IDLE)
				begin
					if (pwrite_i)
					begin
						mem_we = 1'h1;
						s_next.pready = 1'h1;
					end
					else
					begin
						s_next.apb_pend = 1'h1;
					end
				end
			end
			else
			begin
				s_next.pslverr = 1'h1;
			end
		end

		// A new event wins over a clear in the same cycle
		s_next.int_stat = fod_pkg::fod_irq_t'((s_reg.int_stat & ~clr) | ev);
		s_next.irq = (s_next.int_stat & s_next.int_mask) != 3'h0;
		s_next.ready = s_next.state == fod_pkg::ST_IDLE;
	end

	// Registers the whole state in one place
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_reg <= '0;
			s_reg.state <= fod_pkg::ST_IDLE;
			s_reg.ready <= 1'h1;
			s_reg.align_en <= fod_pkg::ALIGN_EN_RST;
			s_reg.int_mask <= fod_pkg::fod_irq_t'(fod_pkg::IRQ_MASK_RST);
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign prdata_o = s_reg.prdata;
	assign pready_o = s_reg.pready;
	assign pslverr_o = s_reg.pslverr;
	assign irq_o = s_reg.irq;
	assign issue_ready_o = s_reg.ready;
	assign outcome_o = s_reg.outc;
	assign rtn_req_o = s_reg.req;

	// ==========================================================================
	// Checks
	logic [2:0] rd_seen_reg;
	logic [2:0] wr_seen_reg;
	logic accept;

	assign accept = s_reg.state == fod_pkg::ST_IDLE && issue_valid_i;

	// Counts words moved per operation, for the checks only
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_seen_reg <= 3'h0;
			wr_seen_reg <= 3'h0;
		end
		else if (accept)
		begin
			rd_seen_reg <= 3'h0;
			wr_seen_reg <= 3'h0;
		end
		else
		begin
			rd_seen_reg <= rd_seen_reg + 3'(s_reg.state == fod_pkg::ST_RD_DATA);
			wr_seen_reg <= wr_seen_reg + 3'(s_reg.state == fod_pkg::ST_WR);
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	quad_rd_fault_a: assert property (accept && s_reg.align_en && iss_dst_p == fod_pkg::PREC_Q
		&& issue_i.rd[1:0] != 2'h0 |=> outcome_o.done && outcome_o.trap && issue_ready_o)
		else $error("quad destination misalignment not trapped");
	quad_rs2_fault_a: assert property (accept && s_reg.align_en && iss_src_p == fod_pkg::PREC_Q
		&& issue_i.rs2[1:0] != 2'h0 |=> outcome_o.done && outcome_o.ftt == fod_pkg::FTT_INVALID_REG)
		else $error("quad source misalignment not trapped");
	fault_flags_a: assert property (outcome_o.done && outcome_o.ftt == fod_pkg::FTT_INVALID_REG
		|-> outcome_o.trap && outcome_o.fp_exc && $past(s_reg.state) == fod_pkg::ST_IDLE)
		else $error("misaligned fault flags wrong");
	write_width_a: assert property (s_reg.state == fod_pkg::ST_WR ##1 s_reg.state == fod_pkg::ST_IDLE
		|-> wr_seen_reg == fod_pkg::fod_words(dst_p) && outcome_o.done)
		else $error("result word count differs from destination precision");
	texc_capture_a: assert property (s_reg.state == fod_pkg::ST_CALL && rtn_rsp_i.done
		|=> outcome_o.texc == $past(rtn_rsp_i.texc) && !rtn_req_o.valid)
		else $error("exception vector not captured");
	fcc_capture_a: assert property (s_reg.state == fod_pkg::ST_CALL && rtn_rsp_i.done
		|=> outcome_o.fcc == $past(rtn_rsp_i.fcc))
		else $error("condition code not captured");
	source_count_a: assert property ($rose(rtn_req_o.valid)
		|-> rd_seen_reg == fod_pkg::fod_words(src_p) && s_reg.state == fod_pkg::ST_CALL)
		else $error("source word count differs from source precision");
	negate_word_a: assert property (s_reg.state == fod_pkg::ST_RD_DATA
		&& s_reg.req.op == fod_pkg::SINGLE_NEGATE_OP
		|=> s_reg.state == fod_pkg::ST_WR && s_reg.outc.texc == 5'h0
		&& s_reg.result[fod_pkg::OPND_W-1 -: fod_pkg::WORD_W] == ($past(mem_rdata) ^ fod_pkg::SIGN_MASK))
		else $error("negate result wrong");
	unfinished_a: assert property (s_reg.state == fod_pkg::ST_CALL && rtn_rsp_i.done
		&& !rtn_rsp_i.complete |=> outcome_o.done && outcome_o.fp_exc
		&& s_reg.state == fod_pkg::ST_IDLE ##1 !$past(mem_we))
		else $error("unfinished operation not reported");

	quad_root_c: cover property (accept && issue_i.op == fod_pkg::QUAD_ROOT_OP ##[1:40] outcome_o.done);
	misaligned_c: cover property (outcome_o.done && outcome_o.ftt == fod_pkg::FTT_INVALID_REG);
	unfinished_c: cover property (outcome_o.done && outcome_o.ftt == fod_pkg::FTT_UNFINISHED);
	magnitude_c: cover property (s_reg.state == fod_pkg::ST_WR && s_reg.req.op == fod_pkg::SINGLE_MAGNITUDE_OP);

endmodule : fod_dispatch

/* verif/fod_rtn_model.sv */
`timescale 1ns/100ps
// ==========================================================================
// Arithmetic routine stand-in: answers after a chosen wait, result is the
// inverted operand so every word of the request shows in the reply
module fod_rtn_model (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire fod_pkg::fod_req_t req_i,
	input wire logic complete_i,
	input wire logic [2:0] delay_i,
	output fod_pkg::fod_rsp_t rsp_o
);
	logic [2:0] wait_cnt;
	logic [31:0] noise;

	// Outside an answer the result lines churn, so a stale capture is seen
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rsp_o <= '0;
			wait_cnt <= 3'h0;
			noise <= 32'h1357_9BDF;
		end
		else
		begin
			noise <= {noise[30:0], ~(noise[31] ^ noise[21])};
			rsp_o.done <= 1'h0;
			rsp_o.result <= {4{noise}};
			if (req_i.valid && !rsp_o.done)
			begin
				if (wait_cnt >= delay_i)
				begin
					// Result, exception vector, condition code, completion
					rsp_o.done <= 1'h1;
					rsp_o.result <= ~req_i.operand;
					rsp_o.texc <= req_i.operand[4:0];
					rsp_o.fcc <= req_i.operand[6:5];
					rsp_o.complete <= complete_i;
					wait_cnt <= 3'h0;
				end
				else
					wait_cnt <= wait_cnt + 3'h1;
			end
		end
	end
endmodule : fod_rtn_model

/* verif/fod_dispatch_tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
// ==========================================================================
// Self-checking bench: APB register access, random operate issues
module fod_dispatch_tb_top;
	logic clk_sys_i = 1'h0, arst_n_i = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic ivalid = 1'h0, cpl = 1'h1, pready, pslverr, irq, iready, errv;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv, r, seed = 32'h86EB;
	logic [31:0] sh [32];
	logic [2:0] dly = 3'h0;
	// Condition code the design should still hold; moves and misaligned faults leave it alone
	logic [1:0] efcc = 2'h0;
	fod_pkg::fod_issue_t issue = '0;
	fod_pkg::fod_outcome_t outc, got;
	fod_pkg::fod_req_t req;
	fod_pkg::fod_rsp_t rsp;
	int fail_count = 0, n_checks = 0, i, n;

	fod_dispatch i_fod_dispatch (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .issue_valid_i(ivalid), .issue_i(issue),
		.issue_ready_o(iready), .outcome_o(outc), .rtn_req_o(req), .rtn_rsp_i(rsp));
	fod_rtn_model i_fod_rtn_model (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_i(req),
		.complete_i(cpl), .delay_i(dly), .rsp_o(rsp));

	// ==========================================================================
	// Clock
	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Words of the source (s=1) or destination group, by opcode order
	function automatic int nw(input int k, input logic s);
		if (s)
			return (k inside {4, 8, 9, 16}) ? 2 : (k inside {5, 10, 11, 17}) ? 4 : 1;
		return (k inside {1, 6, 11, 16}) ? 2 : (k inside {2, 7, 9, 17}) ? 4 : 1;
	endfunction : nw

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	// One APB transfer; the request holds until pready is seen at an edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		int t;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'h1;
		for (t = 0; t < 40; t++)
		begin
			@(posedge clk_sys_i);
			if (pready === 1'h1)
				break;
		end
		if (t == 40)
		begin
			fail_count++;
			tally_and_finish();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys_i);
	endtask : apb

	// Issue one operate, check its outcome, then read back the destination
	task automatic trial(input int k, input logic [4:0] rd, input logic [4:0] rs2, input logic en);
		int ns, nd, t;
		logic [4:0] sb, db;
		logic [127:0] opnd, res;
		logic mis, ok, mv, c;
		ns = nw(k, 1'h1);
		nd = nw(k, 1'h0);
		sb = rs2 & ~5'(ns - 1);
		db = rd & ~5'(nd - 1);
		mis = en && (sb != rs2 || db != rd);
		mv = k >= 12 && k <= 14;
		c = (rnd() % 5) != 0;
		ok = mv || c;
		opnd = '0;
		for (t = 0; t < ns; t++)
			opnd = {opnd[95:0], sh[sb + 5'(t)]};
		res = ~opnd;
		if (k == 12)
			res = opnd;
		if (k == 13)
			res = opnd ^ 128'h8000_0000;
		if (k == 14)
			res = opnd & 128'h7FFF_FFFF;
		cpl <= c;
		dly <= 3'(rnd());
		issue <= '{fod_pkg::fod_op_t'(k[4:0]), rd, rs2};
		ivalid <= 1'h1;
		@(posedge clk_sys_i);
		ivalid <= 1'h0;
		for (t = 0; t < 60; t++)
		begin
			@(posedge clk_sys_i);
			if (outc.done === 1'h1)
				break;
			`CHK(iready, 1'h0)
		end
		if (t == 60)
		begin
			fail_count++;
			tally_and_finish();
		end
		got = outc;
		`CHK(iready, 1'h1)
		`CHK({got.trap, got.fp_exc, got.ftt}, {!ok | mis, !ok | mis, mis ? 3'h6 : ok ? 3'h0 : 3'h2})
		if (!mis)
			`CHK({got.texc, got.fcc}, mv ? {5'h0, efcc} : {opnd[4:0], opnd[6:5]})
		if (!mis && !mv)
			efcc = opnd[6:5];
		if (!mis && ok)
			for (t = 0; t < nd; t++)
				sh[db + 5'(t)] = res[32 * (nd - 1 - t) +: 32];
		for (t = 0; t < nd; t++)
		begin
			apb(1'h1, fod_pkg::ADDR_FREG_INDEX, 32'(db) + 32'(t));
			apb(1'h0, fod_pkg::ADDR_FREG_DATA, 32'h0);
			`CHK(rdv, sh[db + 5'(t)])
		end
	endtask : trial

	// ==========================================================================
	// Main sequence: reset, register map, interrupt, random issues
	initial
	begin
		repeat (10) @(posedge clk_sys_i);
		arst_n_i <= 1'h1;
		repeat (3) @(posedge clk_sys_i);
		apb(1'h0, fod_pkg::ADDR_CTRL, 32'h0);
		`CHK(rdv[0], 1'h1)
		apb(1'h0, 32'h0000_0020, 32'h0);
		`CHK({errv, rdv}, 33'h1_0000_0000)
		for (i = 0; i < 32; i++)
		begin
			sh[i] = rnd();
			apb(1'h1, fod_pkg::ADDR_FREG_INDEX, 32'(i));
			apb(1'h1, fod_pkg::ADDR_FREG_DATA, sh[i]);
		end
		// Misaligned quad root raises the unmasked interrupt, then clear it
		apb(1'h1, fod_pkg::ADDR_IRQ_MASK, 32'h2);
		trial(17, 5'h4, 5'h5, 1'h1);
		`CHK(irq, 1'h1)
		// Status shows trap, exception and the invalid-register type, not busy
		apb(1'h0, fod_pkg::ADDR_STATUS, 32'h0);
		`CHK(rdv, 32'h0000_0F00)
		apb(1'h0, fod_pkg::ADDR_IRQ_STATUS, 32'h0);
		`CHK(rdv[2:0], 3'h3)
		apb(1'h1, fod_pkg::ADDR_IRQ_STATUS, 32'h2);
		repeat (2) @(posedge clk_sys_i);
		`CHK(irq, 1'h0)
		// Second half runs with the alignment check off
		for (n = 0; n < 120; n++)
		begin
			if (n == 60)
				apb(1'h1, fod_pkg::ADDR_CTRL, 32'h0);
			r = rnd();
			trial(int'(rnd() % 18), (r[9:8] == 2'h0) ? r[4:0] : r[4:0] & 5'h1C,
				(r[11:10] == 2'h0) ? r[16:12] : r[16:12] & 5'h1C, n < 60);
		end
		tally_and_finish();
	end
endmodule : fod_dispatch_tb_top
